// >>> logic/hall_measure.sv
// Measurement sequencer, wake-up compare and register slave of the hall sensor
`default_nettype none
module hall_measure
    import hall_pkg::*;
#(
    parameter int RATE_UNIT = RATE_UNIT_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Register bus
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Supply monitor pins
    input wire logic supply_ok_in,
    input wire logic restart_evt_in,
    // Serial bus pins, observed only
    input wire logic scl_in,
    input wire logic sda_in,
    // Analog front end control
    output logic bias_en_out,
    output logic reset_det_en_out,
    output logic osc_fast_en_out,
    output logic hall_bias_en_out,
    output logic [1:0] mux_sel_out,
    output logic adc_start_out,
    input wire logic adc_done_in,
    input wire logic [ADC_W-1:0] adc_data_in,
    // Open-drain interrupt pin
    output logic int_n_o_out,
    output logic int_oe_out
);
    seq_state_t state_q, state_d;
    logic [15:0] wait_q;
    logic [1:0] ch_q;
    logic boot_done_q;
    logic [2:0] oow_q;
    logic start_req_q;
    logic temp_en_q, wake_en_q, coll_en_q;
    logic [1:0] mode_q;
    logic [7:0] rate_q;
    logic [23:0] rate_cnt_q;
    logic [ADC_W-1:0] thr_hi_q [3];
    logic [ADC_W-1:0] thr_lo_q [3];
    logic [2:0] out_win;
    logic wr_q, rd_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic take, reg_wr, ctrl_wr, trig, reconf, periodic_tick;
    logic last_ch, conv_done, busy, cycle_done, int_evt, int_pend_q, bus_busy_q;
    logic [15:0] int_cnt_q;
    logic sup_s1_q, sup_s2_q, rst_s1_q, rst_s2_q, rst_s3_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    logic restart_evt;

    result_if #(.DW(ADC_W), .AW(2)) res ();

    result_mem #(.DEPTH(4), .DW(ADC_W)) u_mem (
        .clock_in(clock_in),
        .port(res.mem)
    );

    // Pin synchronisers; edges are found past the second stage
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
            rst_s3_q <= 1'b0;
        end
        else
        begin
            sup_s1_q <= supply_ok_in;
            sup_s2_q <= sup_s1_q;
            rst_s1_q <= restart_evt_in;
            rst_s2_q <= rst_s1_q;
            rst_s3_q <= rst_s2_q;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in; // R1
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    assign restart_evt = rst_s2_q && !rst_s3_q;

    // Bus busy between start and stop condition; device never drives the bus
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            bus_busy_q <= 1'b0;
        end
        else if (scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q)
        begin
            bus_busy_q <= 1'b1; // R17
        end
        else if (scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q)
        begin
            bus_busy_q <= 1'b0;
        end
    end

    // Register slave: writes in data phase, reads take one wait state
    assign take = hsel_in && htrans_in[1] && hready_in;
    assign reg_wr = wr_q;
    assign ctrl_wr = reg_wr && (addr_q == CTRL_OFS);
    assign trig = ctrl_wr && hwdata_in[CTRL_TRIG_BIT];
    assign reconf = reg_wr && (addr_q == CTRL_OFS || (addr_q >= THR_X_OFS
        && addr_q <= THR_X_OFS + 8'h08));
    assign hreadyout_out = !rd_q;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_q <= take && hwrite_in;
            rd_q <= take && !hwrite_in;
            if (take)
            begin
                addr_q <= {haddr_in[7:2], 2'b00};
            end
        end
    end

    // Memory read address follows the address phase so data is ready next cycle
    assign res.raddr = 2'(haddr_in[4:2] - 3'h2);

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (rd_q)
        begin
            if (addr_q == CTRL_OFS)
            begin
                hrdata_q <= {16'h0000, rate_q, 2'b00, mode_q, coll_en_q, wake_en_q,
                    temp_en_q, 1'b0};
            end
            else if (addr_q == STAT_OFS)
            begin
                hrdata_q <= {22'h000000, state_q, oow_q, bus_busy_q, !sup_s2_q,
                    boot_done_q, busy};
            end
            else if (addr_q >= RES_X_OFS && addr_q <= RES_T_OFS)
            begin
                hrdata_q <= {20'h00000, res.rdata};
            end
            else if (addr_q >= THR_X_OFS && addr_q <= THR_X_OFS + 8'h08)
            begin
                hrdata_q <= {4'h0, thr_hi_q[2'(addr_q[3:2] - 2'h2)], 4'h0,
                    thr_lo_q[2'(addr_q[3:2] - 2'h2)]};
            end
            else
            begin
                hrdata_q <= 32'h0000_0000;
            end
        end
    end

    // Settings take effect immediately, no restart needed
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            temp_en_q <= TEMP_EN_RST; // R6
            wake_en_q <= 1'b0;
            coll_en_q <= 1'b0;
            mode_q <= MODE_RST;
            rate_q <= RATE_RST;
        end
        else if (ctrl_wr)
        begin
            temp_en_q <= hwdata_in[CTRL_TEMP_BIT];
            wake_en_q <= hwdata_in[CTRL_WAKE_BIT];
            coll_en_q <= hwdata_in[CTRL_COLL_BIT];
            mode_q <= hwdata_in[CTRL_MODE_LSB +: 2]; // R10
            rate_q <= hwdata_in[CTRL_RATE_LSB +: 8]; // R10
        end
    end

    // Per-axis window registers and compare against the new result
    for (genvar i = 0; i < 3; i++)
    begin : g_axis
        always_ff @(posedge clock_in)
        begin
            if (rst_in)
            begin
                thr_hi_q[i] <= THR_HI_RST;
                thr_lo_q[i] <= THR_LO_RST;
            end
            else if (reg_wr && addr_q == THR_X_OFS + 8'(4 * i))
            begin
                thr_hi_q[i] <= hwdata_in[THR_HI_LSB +: ADC_W]; // R13
                thr_lo_q[i] <= hwdata_in[ADC_W-1:0]; // R13
            end
        end
        assign out_win[i] = (ch_q == 2'(i)) && ($signed(adc_data_in) > $signed(thr_hi_q[i])
            || $signed(adc_data_in) < $signed(thr_lo_q[i])); // R13 R14
    end

    // Periodic wake-up in periodic mode; fast mode re-runs back to back
    always_ff @(posedge clock_in)
    begin
        if (rst_in || mode_q != MODE_PERIODIC || state_q != SEQ_LOWPWR)
        begin
            rate_cnt_q <= 24'h000000;
        end
        else
        begin
            rate_cnt_q <= periodic_tick ? 24'h000000 : rate_cnt_q + 24'h000001;
        end
    end
    assign periodic_tick = mode_q == MODE_PERIODIC
        && rate_cnt_q >= 24'(rate_q) * 24'(RATE_UNIT) - 24'h000001;

    // Start request; a new request in the same cycle as the take wins
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            start_req_q <= 1'b0;
        end
        else if (reconf || trig || periodic_tick || (mode_q == MODE_FAST && cycle_done))
        begin
            start_req_q <= 1'b1; // R3 R11
        end
        else if (state_q == SEQ_LOWPWR && state_d == SEQ_BIAS)
        begin
            start_req_q <= 1'b0;
        end
    end

    assign busy = state_q != SEQ_LOWPWR;
    assign conv_done = state_q == SEQ_WAIT && adc_done_in;
    assign last_ch = ch_q == CH_T || (ch_q == CH_Z && !temp_en_q); // R6
    assign cycle_done = state_q == SEQ_DONE;

    always_comb
    begin
        state_d = state_q;
        if (!sup_s2_q && busy)
        begin
            state_d = SEQ_HALT; // R8
        end
        else if (restart_evt && busy && state_q != SEQ_HALT)
        begin
            state_d = boot_done_q ? SEQ_BIAS : SEQ_BOOT; // R9
        end
        else
        begin
            case (state_q)
                SEQ_BOOT: if (wait_q == 16'(BIAS_SETTLE_CYC - 1)) state_d = SEQ_LOWPWR; // R2
                SEQ_LOWPWR: if (start_req_q) state_d = SEQ_BIAS;
                SEQ_BIAS: if (wait_q == 16'(BIAS_SETTLE_CYC - 1)) state_d = SEQ_HALL; // R4
                SEQ_HALL: if (wait_q == 16'(HALL_SETTLE_CYC - 1)) state_d = SEQ_CONV; // R4
                SEQ_CONV: state_d = SEQ_WAIT;
                SEQ_WAIT: if (adc_done_in) state_d = last_ch ? SEQ_DONE : SEQ_CONV;
                SEQ_DONE: state_d = SEQ_LOWPWR; // R4
                SEQ_HALT: state_d = boot_done_q ? SEQ_BIAS : SEQ_BOOT; // R8
                default: state_d = SEQ_BOOT;
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_q <= SEQ_BOOT;
            wait_q <= 16'h0000;
            boot_done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // Restart into the same state must still clear the settle count
            wait_q <= (state_d != state_q || (restart_evt && busy && sup_s2_q)) ? 16'h0000
                : wait_q + 16'h0001; // R9
            if (state_q == SEQ_BOOT && state_d == SEQ_LOWPWR)
            begin
                boot_done_q <= 1'b1;
            end
        end
    end

    // Channel walk X, Y, Z, then temperature
    always_ff @(posedge clock_in)
    begin
        if (rst_in || state_q == SEQ_HALL)
        begin
            ch_q <= 2'h0;
        end
        else if (conv_done && !last_ch)
        begin
            ch_q <= ch_q + 2'h1; // R5
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in || state_q == SEQ_HALL)
        begin
            oow_q <= 3'h0;
        end
        else if (conv_done && ch_q != CH_T)
        begin
            oow_q <= oow_q | out_win;
        end
    end

    // Each result lands in the store as it is converted, before the cycle ends
    assign res.we = conv_done; // R21
    assign res.waddr = ch_q;
    assign res.wdata = (ch_q == CH_T) ? {2'b00, adc_data_in[ADC_W-1 -: TEMP_W]}
        : adc_data_in; // R7

    assign bias_en_out = state_q != SEQ_LOWPWR && state_q != SEQ_HALT; // R2 R4
    assign reset_det_en_out = bias_en_out; // R2
    assign osc_fast_en_out = bias_en_out; // R2 R4
    assign hall_bias_en_out = state_q == SEQ_HALL || state_q == SEQ_CONV
        || state_q == SEQ_WAIT; // R4
    assign mux_sel_out = ch_q; // R5
    assign adc_start_out = state_q == SEQ_CONV && sup_s2_q; // R8

    // Completion or wake-up event; wake mode fires only on an axis outside its window
    assign int_evt = cycle_done && (!wake_en_q || (|oow_q)); // R12 R15 R16

    // Pulse held back, not lost, while collision avoidance sees bus traffic
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            int_pend_q <= 1'b0;
            int_cnt_q <= 16'h0000;
        end
        else
        begin
            if (int_evt)
            begin
                int_pend_q <= 1'b1;
            end
            else if (int_pend_q && int_cnt_q == 16'h0000 && !(coll_en_q && bus_busy_q))
            begin
                int_pend_q <= 1'b0; // R17
            end
            if (int_pend_q && int_cnt_q == 16'h0000 && !(coll_en_q && bus_busy_q))
            begin
                int_cnt_q <= 16'(INT_PULSE_CYC); // R14
            end
            else if (int_cnt_q != 16'h0000)
            begin
                int_cnt_q <= int_cnt_q - 16'h0001;
            end
        end
    end

    assign int_n_o_out = 1'b0; // R18 R20
    assign int_oe_out = int_cnt_q != 16'h0000; // R18 R14
endmodule
`default_nettype wire

// >>> logic/hall_pkg.sv
// Constants, register map and types of the hall sensor sequencer
// Notes on behaviour
// (R1) Sensor is bus slave, never initiates transfers
// (R2) Boot enables bias, reset detector, fast oscillator
// (R3) Each reconfiguration starts one measurement cycle
// (R4) Cycle: bias and check, hall bias, convert, return
// (R5) X, Y, Z muxed into one converter sequentially
// (R6) Optional temperature after axes, enabled at reset
// (R7) Axes 12-bit results, temperature 10-bit
// (R8) Low supply halts; restart function from beginning
// (R9) Restart event mid-function aborts and restarts it
// (R10) Rate and power mode changeable any time
// (R11) Master trigger starts a conversion cycle
// (R12) Interrupt output flags valid measurement result
// (R13) Per-axis upper and lower thresholds compared
// (R14) Out-of-window axis result pulses active-low interrupt
// (R15) All axes inside window: no wake-up interrupt
// (R16) Wake-up interrupt is OR of axes
// (R17) Collision avoidance suppresses pulses during bus activity
// (R18) Interrupt pin is open-drain, active low
// (R19) Clock stretching needs interrupt tied to clock
// (R20) Separate interrupt wiring: no clock stretching relied on
// (R21) Results stored before completion interrupt
`default_nettype none
package hall_pkg;
    localparam int CLK_MHZ = 200;
    localparam int BIAS_SETTLE_NS = 500;
    localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int HALL_SETTLE_NS = 1000;
    localparam int HALL_SETTLE_CYC = (HALL_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int INT_PULSE_NS = 1000;
    localparam int INT_PULSE_CYC = (INT_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RATE_UNIT_NS = 10000;
    localparam int RATE_UNIT_CYC = (RATE_UNIT_NS * CLK_MHZ) / 1000;
    localparam int ADC_W = 12;
    localparam int TEMP_W = 10;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] RES_X_OFS = 8'h08;
    localparam logic [7:0] RES_T_OFS = 8'h14;
    localparam logic [7:0] THR_X_OFS = 8'h18;
    localparam int CTRL_TRIG_BIT = 0;
    localparam int CTRL_TEMP_BIT = 1;
    localparam int CTRL_WAKE_BIT = 2;
    localparam int CTRL_COLL_BIT = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_RATE_LSB = 8;
    localparam int THR_HI_LSB = 16;
    localparam logic [1:0] MODE_LOW = 2'h0;
    localparam logic [1:0] MODE_PERIODIC = 2'h1;
    localparam logic [1:0] MODE_FAST = 2'h2;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [7:0] RATE_RST = 8'h0A;
    localparam logic TEMP_EN_RST = 1'b1;
    localparam logic [1:0] CH_Z = 2'h2;
    localparam logic [1:0] CH_T = 2'h3;
    localparam logic [ADC_W-1:0] THR_HI_RST = 12'h7FF;
    localparam logic [ADC_W-1:0] THR_LO_RST = 12'h800;
    typedef enum logic [2:0] {
        SEQ_BOOT, SEQ_LOWPWR, SEQ_BIAS, SEQ_HALL, SEQ_CONV, SEQ_WAIT, SEQ_DONE, SEQ_HALT
    } seq_state_t;
endpackage
`default_nettype wire

// >>> logic/result_if.sv
// Result store port between sequencer and result memory
`default_nettype none
interface result_if #(parameter int DW = 12, parameter int AW = 2);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> logic/result_mem.sv
// Small result memory with registered read data
`default_nettype none
module result_mem #(
    parameter int DEPTH = 4,
    parameter int DW = 12
) (
    input wire logic clock_in,
    result_if.mem port
);
    logic [DW-1:0] mem_q [DEPTH];

    always_ff @(posedge clock_in)
    begin
        if (port.we)
        begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge clock_in)
    begin
        port.rdata <= mem_q[port.raddr];
    end
endmodule
`default_nettype wire

// >>> tb/front_end_model.sv
// Behavioural converter front end answering each start after a set delay
`default_nettype none
module front_end_model (
    // Clock
    input wire logic clock_in,
    // Sequencer side
    input wire logic start_in,
    input wire logic [1:0] chan_in,
    input wire logic armed_in,
    output logic done_out,
    output logic [11:0] data_out,
    // Bench control
    input wire logic [47:0] vals_in,
    input wire logic [3:0] lat_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy_q = 1'b0;
    logic done_q = 1'b0;
    logic [3:0] cnt_q = 4'h0;
    logic [1:0] ch_q = 2'h0;
    logic [11:0] data_q = 12'h000;
    assign done_out = done_q;
    assign data_out = data_q;
    always @(posedge clock_in)
    begin
        done_q <= 1'b0;
        // Data toggles outside the done cycle so a late sample shows up
        data_q <= ~data_q;
        if (!armed_in)
            busy_q <= 1'b0;
        else if (start_in)
        begin
            busy_q <= 1'b1;
            cnt_q <= lat_in;
            ch_q <= chan_in;
        end
        else if (busy_q && cnt_q == 4'h0)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            data_q <= vals_in[ch_q * 12 +: 12];
        end
        else if (busy_q)
            cnt_q <= cnt_q - 4'h1;
    end
endmodule
`default_nettype wire

// >>> tb/hall_measure_checker.sv
// Port-level assertions for the hall sensor measurement block
`default_nettype none
module hall_measure_checker (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Watched ports
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic supply_ok_in,
    input wire logic bias_en_out,
    input wire logic reset_det_en_out,
    input wire logic osc_fast_en_out,
    input wire logic hall_bias_en_out,
    input wire logic [1:0] mux_sel_out,
    input wire logic adc_start_out,
    input wire logic int_n_o_out,
    input wire logic int_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] pulse_q;
    logic first_q;
    logic [1:0] last_q;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // Pulse length counted here, a 200-deep repetition would crawl
    always_ff @(posedge clock_in)
    begin
        if (rst_in || !int_oe_out)
            pulse_q <= 9'h000;
        else
            pulse_q <= pulse_q + 9'h001;
    end
    always_ff @(posedge clock_in)
    begin
        if (rst_in || !hall_bias_en_out)
            first_q <= 1'b1;
        else if (adc_start_out)
            first_q <= 1'b0;
    end
    always_ff @(posedge clock_in)
    begin
        if (adc_start_out)
            last_q <= mux_sel_out;
    end
    bias_group_a:
        assert property (bias_en_out == reset_det_en_out && bias_en_out == osc_fast_en_out
            && (!hall_bias_en_out || bias_en_out))
        else $error("bias enables disagree");
    conv_pulse_a:
        assert property (adc_start_out |-> hall_bias_en_out ##1 !adc_start_out)
        else $error("conversion start out of place");
    mux_order_a:
        assert property (adc_start_out |-> mux_sel_out == (first_q ? 2'h0 : last_q + 2'h1))
        else $error("channel out of order");
    supply_halt_a:
        assert property ((!supply_ok_in) [*5] |-> !adc_start_out && !hall_bias_en_out)
        else $error("converter active on low supply");
    pulse_len_a:
        assert property ($fell(int_oe_out) |-> pulse_q == 9'h0C8)
        else $error("interrupt pulse too short");
    pulse_cap_a:
        assert property (int_oe_out |-> pulse_q < 9'h0C8)
        else $error("interrupt pulse too long");
    int_drive_a:
        assert property (int_oe_out |-> !int_n_o_out)
        else $error("interrupt pin not pulled low");
    read_wait_a:
        assert property (hsel_in && htrans_in[1] && hready_in && !hwrite_in
            |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    okay_resp_a:
        assert property (!hresp_out)
        else $error("response not okay");
endmodule
bind hall_measure hall_measure_checker chk (
    .clock_in, .rst_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out,
    .hresp_out, .supply_ok_in, .bias_en_out, .reset_det_en_out, .osc_fast_en_out,
    .hall_bias_en_out, .mux_sel_out, .adc_start_out, .int_n_o_out, .int_oe_out
);
`default_nettype wire

// >>> tb/test_hall_measure.sv
// Self-checking bench for the hall sensor measurement block
`default_nettype none
module test_hall_measure
    import hall_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'b0;
    logic [31:0] hwdata_in = 32'h0;
    logic supply_ok_in = 1'b1;
    logic restart_evt_in = 1'b0;
    logic scl_in = 1'b1;
    logic sda_in = 1'b1;
    logic [47:0] vals = 48'hABC055EDC123;
    logic [3:0] lat = 4'h1;
    logic [31:0] hrdata_out;
    logic hreadyout_out;
    logic hresp_out;
    logic bias_en_out;
    logic reset_det_en_out;
    logic osc_fast_en_out;
    logic hall_bias_en_out;
    logic [1:0] mux_sel_out;
    logic adc_start_out;
    logic adc_done_in;
    logic [ADC_W-1:0] adc_data_in;
    logic int_n_o_out;
    logic int_oe_out;
    logic [1:0] chq[$];
    logic seen;
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    logic [35:0] wv [5] = '{36'h010010010, 36'h010010200, 36'h010E00010, 36'h101010010,
        36'h010F00100};
    logic wx [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    always #2.5 clock_in = ~clock_in;
    hall_measure #(.RATE_UNIT(4)) dut (
        .clock_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2),
        .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
        .supply_ok_in, .restart_evt_in, .scl_in, .sda_in, .bias_en_out, .reset_det_en_out,
        .osc_fast_en_out, .hall_bias_en_out, .mux_sel_out, .adc_start_out, .adc_done_in,
        .adc_data_in, .int_n_o_out, .int_oe_out
    );
    front_end_model fe (
        .clock_in, .start_in(adc_start_out), .chan_in(mux_sel_out),
        .armed_in(hall_bias_en_out), .done_out(adc_done_in), .data_out(adc_data_in),
        .vals_in(vals), .lat_in(lat)
    );
    always @(posedge clock_in)
    begin
        if (adc_start_out === 1'b1)
            chq.push_back(mux_sel_out);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic give_up();
        num_errors++;
        tally_and_finish();
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clock_in);
    endtask
    task automatic ready_edge();
        int i;
        i = 0;
        do
        begin
            @(posedge clock_in);
            i++;
        end
        while (hreadyout_out !== 1'b1 && i < 20);
        if (hreadyout_out !== 1'b1)
            give_up();
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        haddr_in <= {24'h000000, a};
        ready_edge();
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        ready_edge();
        q = hrdata_out;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x & m, e);
    endtask
    task automatic wait_int(input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++)
        begin
            @(posedge clock_in);
            seen = (int_oe_out === 1'b1);
        end
    endtask
    task automatic run(input logic [31:0] c);
        chq.delete();
        wr(CTRL_OFS, c);
        wait_int(900);
    endtask
    // Idle means no bias and no pulse for a while, so no request is left over
    task automatic wait_idle();
        int q;
        q = 0;
        for (int i = 0; i < 4000 && q < 30; i++)
        begin
            @(posedge clock_in);
            q = (bias_en_out === 1'b0 && int_oe_out === 1'b0) ? q + 1 : 0;
        end
        if (q < 30)
            give_up();
    endtask
    task automatic order(input int k);
        check(32'(chq.size()), 32'(k));
        foreach (chq[i])
            check({30'h0, chq[i]}, 32'(i));
    endtask
    // Serial start or stop; the interrupt pin stays off the clock line
    task automatic frame(input logic stop);
        sda_in <= stop;
        step(16);
        if (!stop)
        begin
            scl_in <= 1'b0;
            step(16);
            scl_in <= 1'b1;
            step(16);
        end
    endtask
    initial
    begin
        step(2);
        rst_in <= 1'b0;
        step(120);
        rd_chk(CTRL_OFS, 32'hFFFF, 32'h0A02);
        rd_chk(STAT_OFS, 32'h3FF, 32'h082);
        rd_chk(THR_X_OFS, 32'h0FFF0FFF, 32'h07FF0800);
        rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
        run(32'h0A03);
        check(32'(seen), 32'h1);
        order(4);
        for (int i = 0; i < 3; i++)
            rd_chk(RES_X_OFS + 8'(4 * i), 32'hFFF, {20'h0, vals[12 * i +: 12]});
        rd_chk(RES_T_OFS, 32'h3FF, 32'h2AF);
        wait_idle();
        lat <= 4'h9;
        run(32'h0A00);
        order(3);
        wait_idle();
        for (int i = 0; i < 3; i++)
            wr(THR_X_OFS + 8'(4 * i), 32'h01000F00);
        wait_idle();
        for (int i = 0; i < 5; i++)
        begin
            vals <= {12'hABC, wv[i]};
            run(32'h0A04);
            check(32'(seen), 32'(wx[i]));
            order(3);
            wait_idle();
        end
        frame(1'b0);
        run(32'h0A08);
        check(32'(seen), 32'h0);
        frame(1'b1);
        wait_int(40);
        check(32'(seen), 32'h1);
        wait_idle();
        // Third pass restarts inside bias settling, which must start over
        for (int k = 0; k < 3; k++)
        begin
            chq.delete();
            wr(CTRL_OFS, 32'h0A00);
            step(k == 2 ? 50 : 150);
            if (k == 0)
                supply_ok_in <= 1'b0;
            else
                restart_evt_in <= 1'b1;
            step(10);
            supply_ok_in <= 1'b1;
            restart_evt_in <= 1'b0;
            for (n = 0; n < 1000 && adc_start_out !== 1'b1; n++)
                @(posedge clock_in);
            check(32'(n >= 250 && n < 1000), 32'h1);
            wait_int(900);
            check(32'(seen), 32'h1);
            order(3);
            wait_idle();
        end
        // Periodic, then fast mode: a second cycle follows with no new write
        for (int m = 1; m < 3; m++)
        begin
            run({16'h0000, 8'h01, 2'b00, 2'(m), 4'h0});
            step(210);
            wait_int(900);
            check(32'(seen), 32'h1);
            wr(CTRL_OFS, 32'h0A00);
            wait_idle();
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
